// ### dv/fpui_operator.sv
// operator model pressing front panel keys
`timescale 1ns/1ps
module fpui_operator (
   // clock
   input wire logic clk_i,
   // keys toward the panel
   output logic [5:0] key_o
);
   initial key_o = 6'h00;
   // lead keys go down first, the rest two cycles later, so combos have a second press edge
   task automatic press(input logic [5:0] lead, input logic [5:0] keys, input int hold);
      @(negedge clk_i);
      key_o = lead;
      repeat (2) @(negedge clk_i);
      key_o = keys;
      repeat (hold) @(negedge clk_i);
      // released buttons open, read as low
      key_o = 6'h00;
      repeat (12) @(negedge clk_i);
   endtask
endmodule // fpui_operator

// ### dv/testbench.sv
// self-checking bench for the front panel control block
`timescale 1ns/1ps
module testbench;
   localparam int BLINK = 8;
   localparam int CFGP = 32;
   localparam int CFGF = 4;
   localparam int TESTC = 16;
   logic sys_clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic cfg_incomplete_i, cfg_running_i, fail_critical_i, fail_minor_i;
   logic dialogue_i, entry_pending_i;
   logic [3:0] binary_in_line_i, input_lamp_o;
   logic [5:0] det_state_i, key_i, det_lamp_o;
   logic oper_lamp_o, fault_lamp_o, buzzer_o, lcd_black_o, welcome_o, item_flash_o;
   logic [4:0] channel_o;
   logic [1:0] menu_o;
   logic main_view_o, nav_up_o, nav_down_o, nav_cancel_o, nav_ok_o;
   logic mute_signaller_o, mute_buzzer_o, holdon_clear_o;
   logic [7:0] pv;
   logic [31:0] r;
   logic [5:0] altk[3] = '{6'h04, 6'h10, 6'h08};
   int errors = 0;
   int num_checks = 0;
   int pc[8] = '{default: 0};
   int snap[8];
   int c, n;
   always #2 sys_clk_i = ~sys_clk_i;
   fpui_operator i_op (.clk_i(sys_clk_i), .key_o(key_i));
   fpui_top #(.BLINK_CYC(BLINK), .CFG_PERIOD_CYC(CFGP), .CFG_FLASH_CYC(CFGF), .LONG_CYC(20),
      .IDLE_CYC(50), .TEST_CYC(TESTC), .DEB_CYC(3), .NUM_CH(32)) i_dut (.sys_clk_i, .resetn_i,
      .cfg_incomplete_i, .cfg_running_i, .fail_critical_i, .fail_minor_i, .dialogue_i,
      .entry_pending_i, .binary_in_line_i, .det_state_i, .key_i, .oper_lamp_o, .fault_lamp_o,
      .input_lamp_o, .det_lamp_o, .buzzer_o, .lcd_black_o, .welcome_o, .item_flash_o,
      .channel_o, .main_view_o, .menu_o, .nav_up_o, .nav_down_o, .nav_cancel_o, .nav_ok_o,
      .mute_signaller_o, .mute_buzzer_o, .holdon_clear_o);
   // pulse and buzzer-cycle tallies; deltas avoid guessing the exact pulse cycle
   assign pv = {buzzer_o, nav_ok_o, nav_cancel_o, nav_down_o, nav_up_o, holdon_clear_o,
      mute_buzzer_o, mute_signaller_o};
   always @(posedge sys_clk_i) begin
      for (int i = 0; i < 8; i++) begin
         pc[i] += (pv[i] === 1'b1);
      end
   end
   task automatic complete_run();
      if (errors == 0 && num_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %0t seen %0h expected %0h", $time, seen, exp);
      end
   endtask
   task automatic wait_main(input int bound);
      n = 0;
      while (main_view_o !== 1'b1) begin
         if (n == bound) begin
            errors++;
            $display("[FAIL] %0t main view never reached", $time);
            complete_run();
         end
         @(negedge sys_clk_i);
         n++;
      end
   endtask
   task automatic ones(input int sel, input int len, output int cnt);
      cnt = 0;
      repeat (len) begin
         @(negedge sys_clk_i);
         case (sel)
            0: cnt += (oper_lamp_o === 1'b1);
            1: cnt += (fault_lamp_o === 1'b1);
            2: cnt += (item_flash_o === 1'b1);
            default: cnt += (oper_lamp_o === fault_lamp_o);
         endcase
      end
   endtask
   function automatic int dl(input int i);
      return pc[i] - snap[i];
   endfunction
   initial begin
      {cfg_incomplete_i, cfg_running_i, fail_critical_i, fail_minor_i} = 4'h0;
      {dialogue_i, entry_pending_i} = 2'h0;
      binary_in_line_i = 4'h0;
      det_state_i = 6'h00;
      r = $urandom(60794);
      repeat (5) @(negedge sys_clk_i);
      resetn_i = 1'b1;
      repeat (2) @(negedge sys_clk_i);
      chk(buzzer_o, 1);
      chk(lcd_black_o, 1);
      chk(fault_lamp_o, 1);
      repeat (TESTC) @(negedge sys_clk_i);
      chk(welcome_o, 1);
      chk(buzzer_o, 0);
      wait_main(3 * TESTC);
      repeat (8) begin
         r = $urandom();
         binary_in_line_i = r[3:0];
         det_state_i = r[9:4];
         repeat (4) @(negedge sys_clk_i);
         chk(input_lamp_o, r[3:0]);
         chk(det_lamp_o, r[9:4]);
      end
      ones(0, 16, c);
      chk(c, 16);
      fail_critical_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      ones(1, 16, c);
      chk(c, 16);
      fail_critical_i = 1'b0;
      fail_minor_i = 1'b1;
      cfg_incomplete_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      ones(1, 2 * BLINK, c);
      chk(c, BLINK);
      ones(0, 2 * BLINK, c);
      chk(c, BLINK);
      ones(3, 2 * BLINK, c);
      chk(c, 2 * BLINK);
      fail_minor_i = 1'b0;
      cfg_running_i = 1'b1;
      repeat (4) @(negedge sys_clk_i);
      ones(0, CFGP, c);
      chk(c, CFGF);
      {cfg_running_i, cfg_incomplete_i, entry_pending_i} = 3'b001;
      ones(2, 2 * BLINK, c);
      chk(c, 0);
      entry_pending_i = 1'b0;
      n = 1 + ($urandom() % 3);
      c = n;
      repeat (c) i_op.press(6'h02, 6'h02, 8 + ($urandom() % 4));
      i_op.press(6'h01, 6'h01, 8);
      chk(channel_o, c - 1);
      foreach (altk[i]) begin
         snap = pc;
         i_op.press(altk[i], altk[i], 8 + ($urandom() % 4));
         chk(dl(i), 1);
      end
      snap = pc;
      i_op.press(6'h04, 6'h04, 0);
      chk(dl(0), 0);
      i_op.press(6'h20, 6'h20, 8);
      chk(menu_o, 1);
      chk(main_view_o, 0);
      snap = pc;
      i_op.press(6'h04, 6'h0c, 10);
      chk(dl(7), 0);
      snap = pc;
      i_op.press(6'h04, 6'h04, 8);
      i_op.press(6'h08, 6'h08, 8);
      i_op.press(6'h20, 6'h20, 8);
      chk(dl(3) + dl(4), 2);
      chk(dl(6), 1);
      chk(dl(0) + dl(2), 0);
      {dialogue_i, entry_pending_i} = 2'b11;
      repeat (84) @(negedge sys_clk_i);
      ones(2, 2 * BLINK, c);
      chk(c, BLINK);
      entry_pending_i = 1'b0;
      chk(main_view_o, 0);
      snap = pc;
      i_op.press(6'h10, 6'h10, 8);
      chk(main_view_o, 0);
      chk(dl(5), 1);
      dialogue_i = 1'b0;
      i_op.press(6'h10, 6'h10, 8);
      chk(main_view_o, 1);
      chk(dl(1), 0);
      i_op.press(6'h20, 6'h20, 30);
      chk(menu_o, 2);
      repeat (25) @(negedge sys_clk_i);
      chk(main_view_o, 0);
      wait_main(80);
      snap = pc;
      i_op.press(6'h04, 6'h0c, 10);
      chk(main_view_o, 0);
      wait_main(3 * TESTC + 20);
      chk(dl(7), TESTC);
      complete_run();
   end
endmodule // testbench

// ### src/fpui_params.svh
// constants for the front panel control block
`ifndef FPUI_PARAMS_SVH
`define FPUI_PARAMS_SVH
`define FPUI_CLK_HZ 250000000
`define FPUI_BLINK_MS 500
`define FPUI_CFG_PERIOD_MS 2000
`define FPUI_CFG_FLASH_MS 200
`define FPUI_LONG_MS 1000
`define FPUI_IDLE_MS 10000
`define FPUI_TEST_MS 2000
`define FPUI_DEB_US 10000
`define FPUI_MS_CYC(ms) ((ms) * (`FPUI_CLK_HZ / 1000))
`define FPUI_NUM_CH 32
`define FPUI_KEY_LEFT 0
`define FPUI_KEY_RIGHT 1
`define FPUI_KEY_UP 2
`define FPUI_KEY_DOWN 3
`define FPUI_KEY_CANCEL 4
`define FPUI_KEY_OK 5
`endif

// ### src/fpui_pkg.sv
// types for the front panel control block
package fpui_pkg;
   typedef enum logic [4:0] {
      FPUI_TEST = 5'b00001,
      FPUI_WELCOME = 5'b00010,
      FPUI_MAIN = 5'b00100,
      FPUI_MENU = 5'b01000,
      FPUI_BUSY = 5'b10000
   } fpui_view_t;
   typedef enum logic [1:0] {
      FPUI_SRC_NONE = 2'h0,
      FPUI_SRC_DET = 2'h1,
      FPUI_SRC_DEV = 2'h2
   } fpui_menu_t;
endpackage

// ### src/fpui_top.sv
// front panel lamps, keypad decode and view navigation
`timescale 1ns/1ps
`include "fpui_params.svh"
module fpui_top
   import fpui_pkg::*;
#(
   parameter int BLINK_CYC = `FPUI_MS_CYC(`FPUI_BLINK_MS),
   parameter int CFG_PERIOD_CYC = `FPUI_MS_CYC(`FPUI_CFG_PERIOD_MS),
   parameter int CFG_FLASH_CYC = `FPUI_MS_CYC(`FPUI_CFG_FLASH_MS),
   parameter int LONG_CYC = `FPUI_MS_CYC(`FPUI_LONG_MS),
   // ten seconds of cycles overflows a signed 32-bit count, so this one is 64-bit
   parameter longint IDLE_CYC = `FPUI_MS_CYC(longint'(`FPUI_IDLE_MS)),
   parameter int TEST_CYC = `FPUI_MS_CYC(`FPUI_TEST_MS),
   parameter int DEB_CYC = `FPUI_DEB_US * (`FPUI_CLK_HZ / 1000000),
   parameter int NUM_CH = `FPUI_NUM_CH
) (
   // clock and reset
   input wire logic sys_clk_i,
   input wire logic resetn_i,
   // unit status
   input wire logic cfg_incomplete_i,
   input wire logic cfg_running_i,
   input wire logic fail_critical_i,
   input wire logic fail_minor_i,
   // views that must not time out
   input wire logic dialogue_i,
   input wire logic entry_pending_i,
   // binary inputs and detector state
   input wire logic [3:0] binary_in_line_i,
   input wire logic [5:0] det_state_i,
   // keys, active high, from pins
   input wire logic [5:0] key_i,
   // lamps
   output logic oper_lamp_o,
   output logic fault_lamp_o,
   output logic [3:0] input_lamp_o,
   output logic [5:0] det_lamp_o,
   output logic buzzer_o,
   output logic lcd_black_o,
   output logic welcome_o,
   output logic item_flash_o,
   // navigation
   output logic [4:0] channel_o,
   output logic main_view_o,
   output logic [1:0] menu_o,
   output logic nav_up_o,
   output logic nav_down_o,
   output logic nav_cancel_o,
   output logic nav_ok_o,
   // main view actions, one-cycle pulses
   output logic mute_signaller_o,
   output logic mute_buzzer_o,
   output logic holdon_clear_o
);

   function automatic logic [31:0] inc_wrap(input logic [31:0] v, input int lim);
      inc_wrap = (v >= 32'(lim - 1)) ? 32'h0 : v + 32'h1;
   endfunction

   // input synchronisers
   logic [5:0] key_s1, key_s2;
   logic [3:0] bin_s1, bin_s2;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         key_s1 <= 6'h0;
         key_s2 <= 6'h0;
         bin_s1 <= 4'h0;
         bin_s2 <= 4'h0;
      end else begin
         key_s1 <= key_i;
         key_s2 <= key_s1;
         bin_s1 <= binary_in_line_i;
         bin_s2 <= bin_s1;
      end
   end

   // debounce: a key must stay put for DEB_CYC before it counts
   logic [5:0] key_db, key_db_q;
   logic [31:0] deb_cnt [6];
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         key_db <= 6'h0;
         for (int i = 0; i < 6; i++) deb_cnt[i] <= 32'h0;
      end else begin
         for (int i = 0; i < 6; i++) begin
            if (key_s2[i] == key_db[i]) begin
               deb_cnt[i] <= 32'h0;
            end else if (deb_cnt[i] >= 32'(DEB_CYC - 1)) begin
               key_db[i] <= key_s2[i];
               deb_cnt[i] <= 32'h0;
            end else begin
               deb_cnt[i] <= deb_cnt[i] + 32'h1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) key_db_q <= 6'h0;
      else key_db_q <= key_db;
   end

   logic [5:0] press;
   logic combo;
   assign press = key_db & ~key_db_q;
   // up and down together form the test combination
   assign combo = key_db[`FPUI_KEY_UP] & key_db[`FPUI_KEY_DOWN] &
      (press[`FPUI_KEY_UP] | press[`FPUI_KEY_DOWN]);

   // confirm hold timer from the debounced press edge
   logic [31:0] ok_cnt;
   logic ok_long_done;
   logic ok_short, ok_long;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ok_cnt <= 32'h0;
         ok_long_done <= 1'b0;
      end else if (press[`FPUI_KEY_OK]) begin
         ok_cnt <= 32'h0;
         ok_long_done <= 1'b0;
      end else if (key_db[`FPUI_KEY_OK] && !ok_long_done) begin
         ok_cnt <= ok_cnt + 32'h1;
         if (ok_cnt >= 32'(LONG_CYC)) ok_long_done <= 1'b1;
      end
   end
   // long fires while still held, so the menu opens without waiting for release
   assign ok_long = key_db[`FPUI_KEY_OK] && !ok_long_done && ok_cnt >= 32'(LONG_CYC);
   assign ok_short = !key_db[`FPUI_KEY_OK] && key_db_q[`FPUI_KEY_OK] && !ok_long_done;

   // view machine
   fpui_view_t view;
   fpui_menu_t menu;
   logic [31:0] view_cnt;
   logic any_key;
   logic hold_view;
   assign any_key = |(key_db ^ key_db_q);
   assign hold_view = dialogue_i | entry_pending_i;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         view <= FPUI_TEST;
         menu <= FPUI_SRC_NONE;
         view_cnt <= 32'h0;
      end else begin
         view_cnt <= view_cnt + 32'h1;
         unique case (view)
            FPUI_TEST: begin
               if (view_cnt >= 32'(TEST_CYC - 1)) begin
                  view <= FPUI_WELCOME;
                  view_cnt <= 32'h0;
               end
            end
            FPUI_WELCOME: begin
               if (view_cnt >= 32'(TEST_CYC - 1)) begin
                  view <= FPUI_MAIN;
                  view_cnt <= 32'h0;
               end
            end
            FPUI_MAIN: begin
               view_cnt <= 32'h0;
               if (combo) begin
                  view <= FPUI_TEST;
               end else if (ok_long) begin
                  view <= FPUI_MENU;
                  menu <= FPUI_SRC_DEV;
               end else if (ok_short) begin
                  view <= FPUI_MENU;
                  menu <= FPUI_SRC_DET;
               end
            end
            FPUI_MENU, FPUI_BUSY: begin
               if (hold_view) view <= FPUI_BUSY;
               else view <= FPUI_MENU;
               if (any_key || hold_view) begin
                  view_cnt <= 32'h0;
               end else if (view_cnt >= 32'(IDLE_CYC - 1)) begin
                  view <= FPUI_MAIN;
                  menu <= FPUI_SRC_NONE;
                  view_cnt <= 32'h0;
               end
               if (press[`FPUI_KEY_CANCEL] && !hold_view) begin
                  view <= FPUI_MAIN;
                  menu <= FPUI_SRC_NONE;
               end
            end
         endcase
      end
   end

   // channel select
   logic [4:0] channel;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         channel <= 5'h0;
      end else if (press[`FPUI_KEY_RIGHT]) begin
         channel <= 5'(inc_wrap(32'(channel), NUM_CH));
      end else if (press[`FPUI_KEY_LEFT]) begin
         channel <= (channel == 5'h0) ? 5'(NUM_CH - 1) : channel - 5'h1;
      end
   end

   // common blink timer and configuration pulse timer
   logic [31:0] blink_cnt, cfg_cnt;
   logic blink;
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         blink_cnt <= 32'h0;
         blink <= 1'b0;
      end else begin
         blink_cnt <= inc_wrap(blink_cnt, BLINK_CYC);
         if (blink_cnt >= 32'(BLINK_CYC - 1)) blink <= ~blink;
      end
   end
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) cfg_cnt <= 32'h0;
      else cfg_cnt <= inc_wrap(cfg_cnt, CFG_PERIOD_CYC);
   end

   // lamps; the test view overrides everything
   logic in_test;
   assign in_test = (view == FPUI_TEST);
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         oper_lamp_o <= 1'b0;
         fault_lamp_o <= 1'b0;
         input_lamp_o <= 4'h0;
         det_lamp_o <= 6'h0;
         buzzer_o <= 1'b0;
         lcd_black_o <= 1'b0;
         welcome_o <= 1'b0;
         item_flash_o <= 1'b0;
      end else begin
         if (in_test) oper_lamp_o <= 1'b1;
         else if (cfg_running_i) oper_lamp_o <= (cfg_cnt < 32'(CFG_FLASH_CYC));
         else if (cfg_incomplete_i) oper_lamp_o <= blink;
         else oper_lamp_o <= 1'b1;
         if (in_test) fault_lamp_o <= 1'b1;
         else if (fail_critical_i) fault_lamp_o <= 1'b1;
         else fault_lamp_o <= fail_minor_i & blink;
         input_lamp_o <= in_test ? 4'hf : bin_s2;
         det_lamp_o <= in_test ? 6'h3f : det_state_i;
         buzzer_o <= in_test;
         lcd_black_o <= in_test;
         welcome_o <= (view == FPUI_WELCOME);
         item_flash_o <= (view == FPUI_BUSY) & entry_pending_i & blink;
      end
   end

   // navigation and main view actions
   logic in_main, in_menu;
   assign in_main = (view == FPUI_MAIN);
   assign in_menu = (view == FPUI_MENU) | (view == FPUI_BUSY);
   always_ff @(posedge sys_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         channel_o <= 5'h0;
         main_view_o <= 1'b0;
         menu_o <= 2'h0;
         nav_up_o <= 1'b0;
         nav_down_o <= 1'b0;
         nav_cancel_o <= 1'b0;
         nav_ok_o <= 1'b0;
         mute_signaller_o <= 1'b0;
         mute_buzzer_o <= 1'b0;
         holdon_clear_o <= 1'b0;
      end else begin
         channel_o <= channel;
         main_view_o <= in_main;
         menu_o <= menu;
         nav_up_o <= in_menu & press[`FPUI_KEY_UP];
         nav_down_o <= in_menu & press[`FPUI_KEY_DOWN];
         nav_cancel_o <= in_menu & press[`FPUI_KEY_CANCEL];
         nav_ok_o <= in_menu & press[`FPUI_KEY_OK];
         // combo presses are not treated as single-key actions
         mute_signaller_o <= in_main & press[`FPUI_KEY_UP] & !combo;
         holdon_clear_o <= in_main & press[`FPUI_KEY_DOWN] & !combo;
         mute_buzzer_o <= in_main & press[`FPUI_KEY_CANCEL];
      end
   end

   // checks
   test_exit_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      view == FPUI_TEST && view_cnt == 32'(TEST_CYC - 1) |=> view == FPUI_WELCOME)
      else $error("test view did not end on time");
   welcome_exit_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      view == FPUI_WELCOME && view_cnt == 32'(TEST_CYC - 1) |=> view == FPUI_MAIN)
      else $error("welcome did not lead to main view");
   alt_main_only_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      (mute_signaller_o | mute_buzzer_o | holdon_clear_o) |-> $past(in_main))
      else $error("alternative action outside main view");
   combo_test_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      in_main && combo |=> view == FPUI_TEST)
      else $error("combination did not start test");
   short_ok_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      in_main && ok_short && !combo |=> view == FPUI_MENU && menu == FPUI_SRC_DET)
      else $error("short confirm did not open detector menu");
   long_ok_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      in_main && ok_long && !combo |=> menu == FPUI_SRC_DEV)
      else $error("long confirm did not open device menu");
   idle_exit_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      view == FPUI_MENU && !any_key && !hold_view && !press[`FPUI_KEY_CANCEL] &&
      view_cnt == 32'(IDLE_CYC - 1) |=> in_main)
      else $error("idle timeout did not return to main view");
   oper_steady_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      !in_test && !cfg_running_i && !cfg_incomplete_i |=> oper_lamp_o)
      else $error("operation lamp not steady");
   fault_crit_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      fail_critical_i |=> fault_lamp_o)
      else $error("fault lamp not lit on critical failure");
   input_lamp_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      !in_test |=> input_lamp_o == $past(bin_s2))
      else $error("input lamp mismatch");
   right_inc_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      press[`FPUI_KEY_RIGHT] && channel != 5'(NUM_CH - 1) |=> channel == $past(channel) + 5'h1)
      else $error("right key did not increment");
   cancel_exit_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      in_menu && press[`FPUI_KEY_CANCEL] && !hold_view |=> in_main)
      else $error("cancel did not leave menu");
   cancel_block_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
      in_menu && hold_view |=> !in_main)
      else $error("menu left while operator dialogue pending");

endmodule // fpui_top
